// File: common/eic_pkg.sv
// constants and types shared by the extended interrupt control block
package eic_pkg;
  // ==========================================================
  // source map
  localparam int          NSRC          = 15;
  localparam int          IDX_W         = 4;
  localparam int          PRI_SRCS      = 7;
  localparam int          GE_BIT        = 7;
  localparam int          EXT0_SRC      = 0;
  localparam int          EXT1_SRC      = 2;
  localparam logic [14:0] HW_CLEAR_MASK = 15'h000F;
  // ==========================================================
  // handler addresses
  localparam logic [15:0] VEC_BASE      = 16'h0003;
  localparam logic [2:0]  VEC_STEP_ZERO = 3'h0;
  // ==========================================================
  // timing, in core_clk cycles
  localparam int          DETECT_CYCLES = 1;
  localparam logic [2:0]  CALL_CYCLES   = 3'h4;
  localparam logic [2:0]  CALL_LAST     = CALL_CYCLES - 3'h1;
  // ==========================================================
  // reset values
  localparam logic [1:0]  EXT_PIN_IDLE  = 2'h3;
  typedef enum logic [1:0] {
    EIC_ST_IDLE = 2'h1,
    EIC_ST_CALL = 2'h2
  } eic_state_e;
endpackage

// File: hw/eic_arbiter.sv
// two-level fixed-order arbiter for pending interrupt requests
`timescale 1ns/100ps
module eic_arbiter (
  input  wire logic [eic_pkg::NSRC-1:0]  req,
  input  wire logic [eic_pkg::NSRC-1:0]  prio_high,
  output wire logic                      win_valid,
  output wire logic                      win_high,
  output wire logic [eic_pkg::IDX_W-1:0] win_idx
);
  logic                      hi_found;
  logic                      lo_found;
  logic [eic_pkg::IDX_W-1:0] hi_idx;
  logic [eic_pkg::IDX_W-1:0] lo_idx;

  // ==========================================================
  // scan from the top so the lowest index is left standing
  always_comb begin
    hi_found = 1'b0;
    lo_found = 1'b0;
    hi_idx   = '0;
    lo_idx   = '0;
    for (int i = eic_pkg::NSRC - 1; i >= 0; i--) begin
      if (req[i] && prio_high[i]) begin
        hi_found = 1'b1;
        hi_idx   = eic_pkg::IDX_W'(i);
      end
      if (req[i] && !prio_high[i]) begin
        lo_found = 1'b1;
        lo_idx   = eic_pkg::IDX_W'(i);
      end
    end
  end

  assign win_valid = hi_found | lo_found;
  assign win_high  = hi_found;
  assign win_idx   = hi_found ? hi_idx : lo_idx;
endmodule

// File: hw/eic_top.sv
// extended interrupt control: pending flags, gating, arbitration, handler call
// How it works
// - source condition sets its pending flag
// - enabled pending flag raises a request
// - after instruction ends, long call to handler
// - handler return resumes the interrupted program
// - disabled source flag never disturbs program
// - flag sets regardless of enable bit
// - per-source enables count only when global on
// - global enable low blocks every request
// - some flags auto-clear on call, others stay
// - flag still set after return: one instruction, re-enter
// - many sources, each low or high level
// - high preempts low; high never preempted
// - higher level first, then fixed source order
// - sample every cycle; one detect plus four call
// - equal or higher handler running holds request
`timescale 1ns/100ps
module eic_top (
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  input  wire logic [eic_pkg::NSRC-1:0] src_event,
  input  wire logic [1:0]               ext_pin_n,
  input  wire logic [eic_pkg::NSRC-1:0] pend_set,
  input  wire logic [eic_pkg::NSRC-1:0] pend_clr,
  input  wire logic [7:0]               primary_enable_register,
  input  wire logic [7:0]               extended_enable_register_one,
  input  wire logic [7:0]               primary_priority_register,
  input  wire logic [7:0]               extended_priority_register_one,
  input  wire logic                     instr_boundary,
  input  wire logic                     handler_return_instr_done,
  output wire logic [eic_pkg::NSRC-1:0] pending,
  output wire logic                     call_active,
  output wire logic [15:0]              handler_addr,
  output wire logic                     serving_low,
  output wire logic                     serving_high
);
  // ==========================================================
  // configuration decode
  wire logic                      ge;
  wire logic [eic_pkg::NSRC-1:0] en_all;
  wire logic [eic_pkg::NSRC-1:0] prio_all;
  wire logic [eic_pkg::NSRC-1:0] evt_all;
  wire logic [eic_pkg::NSRC-1:0] auto_clr;
  wire logic [1:0]                ext_fall;
  wire logic                      win_valid;
  wire logic                      win_high;
  wire logic [eic_pkg::IDX_W-1:0] win_idx;
  wire logic                      allowed;
  wire logic                      start;
  wire logic [15:0]               vec_w;

  logic [eic_pkg::NSRC-1:0] pend_q;
  logic [eic_pkg::NSRC-1:0] req_q;
  logic [1:0]               ext_meta_q;
  logic [1:0]               ext_sync_q;
  logic [1:0]               ext_prev_q;
  logic [2:0]               cnt_q;
  logic [15:0]              addr_q;
  logic                     act_low_q;
  logic                     act_high_q;
  eic_pkg::eic_state_e      state_q;

  assign ge       = primary_enable_register[eic_pkg::GE_BIT];
  assign en_all   = {extended_enable_register_one,
                     primary_enable_register[eic_pkg::PRI_SRCS-1:0]};
  assign prio_all = {extended_priority_register_one,
                     primary_priority_register[eic_pkg::PRI_SRCS-1:0]};

  // ==========================================================
  // external pins: two-stage sync, then falling-edge detect
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ext_meta_q <= eic_pkg::EXT_PIN_IDLE;
      ext_sync_q <= eic_pkg::EXT_PIN_IDLE;
      ext_prev_q <= eic_pkg::EXT_PIN_IDLE;
    end else begin
      ext_meta_q <= ext_pin_n;
      ext_sync_q <= ext_meta_q;
      ext_prev_q <= ext_sync_q;
    end
  end

  assign ext_fall = ext_prev_q & ~ext_sync_q;

  generate
    for (genvar i = 0; i < eic_pkg::NSRC; i++) begin : g_evt
      if (i == eic_pkg::EXT0_SRC) begin : g_x0
        assign evt_all[i] = src_event[i] | ext_fall[0];
      end else if (i == eic_pkg::EXT1_SRC) begin : g_x1
        assign evt_all[i] = src_event[i] | ext_fall[1];
      end else begin : g_pl
        assign evt_all[i] = src_event[i];
      end
    end
  endgenerate

  // ==========================================================
  // pending flags and registered request detection
  generate
    for (genvar i = 0; i < eic_pkg::NSRC; i++) begin : g_pend
      assign auto_clr[i] = start && (win_idx == eic_pkg::IDX_W'(i))
                           && eic_pkg::HW_CLEAR_MASK[i];
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          pend_q[i] <= 1'b0;
          req_q[i]  <= 1'b0;
        end else begin
          // a set in the clearing cycle wins so no event is lost
          if (evt_all[i] || pend_set[i]) begin
            pend_q[i] <= 1'b1;
          end else if (pend_clr[i] || auto_clr[i]) begin
            pend_q[i] <= 1'b0;
          end
          req_q[i] <= pend_q[i] & en_all[i] & ge;
        end
      end
    end
  endgenerate

  eic_arbiter u_arb (
    .req       (req_q),
    .prio_high (prio_all),
    .win_valid (win_valid),
    .win_high  (win_high),
    .win_idx   (win_idx)
  );

  // ==========================================================
  // preemption and call start
  assign allowed = win_high ? !act_high_q : !(act_high_q || act_low_q);
  // the cycle that ends a return is never a call point, so the core always
  // gets one more instruction in before re-entry
  assign start = (state_q == eic_pkg::EIC_ST_IDLE) && win_valid && allowed
                 && instr_boundary && !handler_return_instr_done;
  assign vec_w = eic_pkg::VEC_BASE + 16'({win_idx, eic_pkg::VEC_STEP_ZERO});

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= eic_pkg::EIC_ST_IDLE;
      cnt_q   <= 3'h0;
      addr_q  <= 16'h0000;
    end else begin
      unique case (state_q)
        eic_pkg::EIC_ST_IDLE: begin
          if (start) begin
            state_q <= eic_pkg::EIC_ST_CALL;
            cnt_q   <= 3'h0;
            addr_q  <= vec_w;
          end
        end
        eic_pkg::EIC_ST_CALL: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == eic_pkg::CALL_LAST) begin
            state_q <= eic_pkg::EIC_ST_IDLE;
          end
        end
        default: begin
          state_q <= eic_pkg::EIC_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // running handler levels; a return retires the innermost one
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      act_low_q  <= 1'b0;
      act_high_q <= 1'b0;
    end else if (start) begin
      if (win_high) begin
        act_high_q <= 1'b1;
      end else begin
        act_low_q <= 1'b1;
      end
    end else if (handler_return_instr_done) begin
      if (act_high_q) begin
        act_high_q <= 1'b0;
      end else begin
        act_low_q <= 1'b0;
      end
    end
  end

  assign pending      = pend_q;
  assign call_active  = (state_q == eic_pkg::EIC_ST_CALL);
  assign handler_addr = addr_q;
  assign serving_low  = act_low_q;
  assign serving_high = act_high_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_call_run;
    call_active [*4] ##1 !call_active;
  endsequence

  AST_PEND_SET: assert property ((src_event != '0) |=>
      ((pend_q & $past(src_event)) == $past(src_event)))
    else $error("event did not set its pending flag");
  AST_GE_OFF: assert property ((!ge ##1 !ge) |-> !start)
    else $error("call started with global enable low");
  AST_CALL_LEN: assert property (start |=> s_call_run)
    else $error("handler call not four cycles");
  AST_NO_HANDLER_RETURN_INSTR_CALL: assert property (handler_return_instr_done |-> !start)
    else $error("call started in the return cycle");
  AST_AUTO_CLR: assert property ((start && eic_pkg::HW_CLEAR_MASK[win_idx]
      && !evt_all[win_idx] && !pend_set[win_idx]) |=> !pend_q[$past(win_idx)])
    else $error("auto-clear flag not cleared on call");
  // req_q trails the flag by one cycle, so a flag cleared just before the call is skipped
  AST_SW_KEEP: assert property ((start && !eic_pkg::HW_CLEAR_MASK[win_idx]
      && pend_q[win_idx] && !pend_clr[win_idx]) |=> pend_q[$past(win_idx)])
    else $error("software-cleared flag dropped by hardware");
  AST_HIGH_HOLD: assert property (act_high_q |-> !start)
    else $error("high handler was preempted");
  AST_LOW_HOLD: assert property ((act_low_q && start) |-> win_high)
    else $error("low handler preempted by low request");
  AST_VECTOR: assert property (start |=>
      (handler_addr == eic_pkg::VEC_BASE + 16'({$past(win_idx), 3'h0})) && call_active)
    else $error("wrong handler address");
  AST_LEVEL_FIRST: assert property ((start && ((req_q & prio_all) != '0)) |-> win_high)
    else $error("low level served before high");
  AST_ENABLED: assert property (start |->
      ($past(ge) && (($past(en_all) & (15'h0001 << win_idx)) != '0)))
    else $error("disabled source was served");
endmodule

// File: verif/eic_cpu_model.sv
// behavioural core model: instruction boundaries, call stalls and handler returns
`timescale 1ns/100ps
module eic_cpu_model (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       call_active,
  input  wire logic [1:0] ilen,
  output logic            instr_boundary,
  output logic            handler_return_instr_done
);
  logic [1:0] cnt;
  logic       ret_want;
  initial begin
    cnt = 2'h0;
    ret_want = 1'b0;
    instr_boundary = 1'b0;
    handler_return_instr_done = 1'b0;
  end
  task automatic request_return;
    ret_want = 1'b1;
  endtask
  // the core stalls for the whole call, so no boundary can fall inside it
  always @(negedge core_clk) begin
    if (!nrst || call_active) begin
      cnt <= 2'h0;
      instr_boundary <= 1'b0;
      handler_return_instr_done <= 1'b0;
    end else begin
      cnt <= (cnt >= ilen) ? 2'h0 : cnt + 2'h1;
      instr_boundary <= (cnt >= ilen);
      // a return always retires on an instruction boundary
      handler_return_instr_done <= (cnt >= ilen) && ret_want;
      if (cnt >= ilen)
        ret_want = 1'b0;
    end
  end
endmodule

// File: verif/tb.sv
// self-checking testbench of the interrupt control block
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb;
  logic        core_clk = 1'b0;
  logic        nrst;
  logic [14:0] src_event, pend_set, pend_clr, pending, exp_p, m;
  logic [1:0]  ext_pin_n, ilen;
  logic [7:0]  primary_enable_register, extended_enable_register_one;
  logic [7:0]  primary_priority_register, extended_priority_register_one;
  logic        instr_boundary, handler_return_instr_done, call_active, serving_low, serving_high;
  logic [15:0] handler_addr;
  logic [2:0]  run = 3'h0;
  logic [31:0] rs = 32'd81;
  logic [16:0] exp_q[$];
  logic [16:0] exp_v;
  int          fails, n_tests;
  always #25 core_clk = ~core_clk;
  eic_top u_dut (.core_clk, .nrst, .src_event, .ext_pin_n, .pend_set, .pend_clr,
    .primary_enable_register, .extended_enable_register_one, .primary_priority_register,
    .extended_priority_register_one, .instr_boundary, .handler_return_instr_done, .pending, .call_active,
    .handler_addr, .serving_low, .serving_high);
  eic_cpu_model u_cpu (.core_clk, .nrst, .call_active, .ilen, .instr_boundary, .handler_return_instr_done);
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [16:0] vec(int i, logic hi);
    return {hi, eic_pkg::VEC_BASE + 16'(i * 8)};
  endfunction
  task automatic summarize;
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pset(logic [14:0] v);
    pend_set = v;
    tick(1);
    pend_set = '0;
  endtask
  task automatic clr(int i);
    pend_clr = 15'h0001 << i;
    tick(1);
    pend_clr = '0;
  endtask
  task automatic drain(int left);
    for (int k = 0; k < 300 && (exp_q.size() > left || call_active); k++)
      tick(1);
    if (exp_q.size() > left || call_active) begin
      fails++;
      summarize();
    end
  endtask
  task automatic ret;
    u_cpu.request_return();
    for (int k = 0; k < 50 && !handler_return_instr_done; k++)
      tick(1);
    if (!handler_return_instr_done) begin
      fails++;
      summarize();
    end
    tick(1);
  endtask
  // ==========================================================
  // monitor: every call start takes the oldest expected vector
  always @(negedge core_clk) if (nrst) begin
    if (call_active && run == 3'h0) begin
      `CHK(exp_q.size() > 0, 1'b1)
      if (exp_q.size() > 0) begin
        exp_v = exp_q.pop_front();
        `CHK({serving_high, handler_addr}, exp_v)
      end
    end
    if (call_active)
      run <= run + 3'h1;
    else if (run != 3'h0) begin
      `CHK(run, eic_pkg::CALL_CYCLES)
      run <= 3'h0;
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    summarize();
  end
  // ==========================================================
  // stimulus
  initial begin
    {nrst, src_event, pend_set, pend_clr, ilen} = '0;
    ext_pin_n = 2'h3;
    {primary_enable_register, extended_enable_register_one} = '0;
    {primary_priority_register, extended_priority_register_one} = '0;
    tick(8);
    `CHK({pending, call_active, handler_addr}, 32'h0)
    nrst = 1'b1;
    exp_p = '0;
    // flags set whatever the enables, but global off blocks every call
    {primary_enable_register, extended_enable_register_one} = 16'h7FFF;
    for (int k = 0; k < 40; k++) begin
      m = 15'(xs());
      src_event = m;
      pend_clr = 15'(xs());
      primary_priority_register = 8'(xs());
      exp_p = (exp_p & ~pend_clr) | m;
      tick(1);
      `CHK(pending, exp_p)
    end
    src_event = '0;
    pend_clr = '1;
    ext_pin_n = 2'h2;
    tick(1);
    pend_clr = '0;
    tick(4);
    ext_pin_n = 2'h0;
    // a pin edge needs three core_clk edges to reach its flag
    tick(2);
    `CHK(pending, 15'h0001)
    tick(1);
    `CHK(pending, 15'h0005)
    ext_pin_n = 2'h3;
    pend_clr = '1;
    primary_priority_register = '0;
    {primary_enable_register, extended_enable_register_one} = 16'h8000;
    tick(1);
    pend_clr = '0;
    pset(15'h0020);
    tick(10);
    // enabling a source whose flag is already set raises the request
    exp_q.push_back(vec(5, 1'b0));
    exp_q.push_back(vec(5, 1'b0));
    primary_enable_register = 8'hE0;
    drain(1);
    `CHK(pending[5], 1'b1)
    ret();
    drain(0);
    clr(5);
    ret();
    `CHK({serving_low, serving_high}, 2'h0)
    exp_q.push_back(vec(6, 1'b0));
    src_event = 15'h0040;
    tick(1);
    src_event = '0;
    tick(1);
    `CHK(call_active, 1'b0)
    tick(1);
    `CHK(call_active, 1'b1)
    drain(0);
    clr(6);
    ret();
    // two levels, preemption and held requests, with a slow core
    ilen = 2'h2;
    primary_enable_register = 8'hD2;
    extended_enable_register_one = 8'h24;
    extended_priority_register_one = 8'h24;
    exp_q.push_back(vec(9, 1'b1));
    exp_q.push_back(vec(1, 1'b0));
    pset(15'h0202);
    drain(1);
    `CHK(pending[1], 1'b1)
    clr(9);
    ret();
    drain(0);
    `CHK(pending[1], 1'b0)
    exp_q.push_back(vec(12, 1'b1));
    pset(15'h1000);
    drain(0);
    `CHK(serving_low, 1'b1)
    exp_q.push_back(vec(4, 1'b0));
    exp_q.push_back(vec(6, 1'b0));
    pset(15'h0050);
    clr(12);
    ret();
    ret();
    drain(1);
    clr(4);
    ret();
    drain(0);
    clr(6);
    ret();
    tick(20);
    `CHK({serving_low, serving_high, exp_q.size() == 0}, 3'h1)
    summarize();
  end
endmodule
